// ---- src/csra_pkg.sv ----
// Shared constants, instruction field layout and state type of the shift/rotate/subtract slice
package csra_pkg;

    localparam int XLEN       = 32;
    localparam int OPC_W      = 6;
    localparam int COND_W     = 4;
    localparam int FLD_W      = 9;
    localparam int CNT_W      = 5;

    // Instruction field positions
    localparam int OPC_LSB    = 26;
    localparam int ZW_BIT     = 25;
    localparam int CW_BIT     = 24;
    localparam int RW_BIT     = 23;
    localparam int IMM_BIT    = 22;
    localparam int COND_LSB   = 18;
    localparam int DST_LSB    = 9;
    localparam int SRC_LSB    = 0;

    // Opcodes
    localparam logic [OPC_W-1:0] OPC_BIT_MIRROR  = 6'h0f;
    localparam logic [OPC_W-1:0] OPC_ROTATE_LEFT = 6'h09;
    localparam logic [OPC_W-1:0] OPC_ROTATE_RIGHT = 6'h08;
    localparam logic [OPC_W-1:0] OPC_ARITH_RIGHT = 6'h0e;
    localparam logic [OPC_W-1:0] OPC_LOGIC_LEFT  = 6'h0b;
    localparam logic [OPC_W-1:0] OPC_LOGIC_RIGHT = 6'h0a;
    localparam logic [OPC_W-1:0] OPC_SUB_UNSIGNED = 6'h21;
    localparam logic [OPC_W-1:0] OPC_JUMP        = 6'h17;

    // Timing and reset values
    localparam int               EXEC_CLOCKS = 4;
    localparam logic [XLEN-1:0]  REG_RESET   = 32'h0000_0000;
    localparam logic             FLAG_RESET  = 1'b0;
    localparam int               REG_DEPTH   = 512;

    typedef enum logic [1:0] {
        CSRA_IDLE,
        CSRA_READ,
        CSRA_EXEC,
        CSRA_COMMIT
    } csra_state_t;

endpackage : csra_pkg

// ---- src/csra_op_if.sv ----
// Operand and answer bundle between the core sequencer and an execution unit
`timescale 1ns/100ps
interface csra_op_if;
    import csra_pkg::*;

    logic [OPC_W-1:0] opcode;
    logic [XLEN-1:0]  dval;
    logic [XLEN-1:0]  sval;
    logic [XLEN-1:0]  result;
    logic             carry;

    modport core (output opcode, output dval, output sval, input result, input carry);
    modport unit (input opcode, input dval, input sval, output result, output carry);

endinterface : csra_op_if

// ---- src/csra_shift_unit.sv ----
// Combinational rotate, shift and bit-mirror unit
`timescale 1ns/100ps
module csra_shift_unit (
    csra_op_if.unit op
);
    import csra_pkg::*;

    function automatic logic [XLEN-1:0] mirror32(input logic [XLEN-1:0] v);
        logic [XLEN-1:0] r;
        r = '0;
        for (int i = 0; i < XLEN; i++) begin
            r[i] = v[XLEN-1-i];
        end
        return r;
    endfunction : mirror32

    logic [CNT_W-1:0]  cnt;
    logic [2*XLEN-1:0] dbl_l;
    logic [2*XLEN-1:0] dbl_r;

    assign cnt   = op.sval[CNT_W-1:0];
    assign dbl_l = {op.dval, op.dval} << cnt;
    assign dbl_r = {op.dval, op.dval} >> cnt;

    always_comb begin
        op.result = '0;
        op.carry  = op.dval[0];
        case (op.opcode)
            OPC_BIT_MIRROR: begin
                op.result = mirror32(op.dval) >> cnt;
                op.carry  = op.dval[0];
            end
            OPC_ROTATE_LEFT: begin
                op.result = dbl_l[2*XLEN-1:XLEN];
                op.carry  = op.dval[XLEN-1];
            end
            OPC_ROTATE_RIGHT: begin
                op.result = dbl_r[XLEN-1:0];
                op.carry  = op.dval[0];
            end
            OPC_ARITH_RIGHT: begin
                op.result = $unsigned($signed(op.dval) >>> cnt);
                op.carry  = op.dval[0];
            end
            OPC_LOGIC_LEFT: begin
                op.result = op.dval << cnt;
                op.carry  = op.dval[XLEN-1];
            end
            OPC_LOGIC_RIGHT: begin
                op.result = op.dval >> cnt;
                op.carry  = op.dval[0];
            end
            default: begin
                op.result = '0;
                op.carry  = op.dval[0];
            end
        endcase
    end

endmodule : csra_shift_unit

// ---- src/csra_sub_unit.sv ----
// Combinational unsigned subtractor with borrow out
`timescale 1ns/100ps
module csra_sub_unit (
    csra_op_if.unit op
);
    import csra_pkg::*;

    logic [XLEN:0] diff;

    assign diff      = {1'b0, op.dval} - {1'b0, op.sval};
    assign op.result = diff[XLEN-1:0];
    assign op.carry  = diff[XLEN];

endmodule : csra_sub_unit

// ---- src/cog_shift_rotate_sub_alu.sv ----
// Sequencer, register file and flags of the shift/rotate/subtract execution slice
`timescale 1ns/100ps
module cog_shift_rotate_sub_alu #(
    parameter int DEPTH = csra_pkg::REG_DEPTH
) (
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    input  wire logic                        instr_valid,
    input  wire logic [csra_pkg::XLEN-1:0]   instr_word,
    output logic                             instr_ready,
    input  wire logic                        load_en,
    input  wire logic [csra_pkg::FLD_W-1:0]  load_addr,
    input  wire logic [csra_pkg::XLEN-1:0]   load_data,
    input  wire logic [csra_pkg::FLD_W-1:0]  peek_addr,
    output logic      [csra_pkg::XLEN-1:0]   peek_data,
    output logic                             done,
    output logic                             executed,
    output logic                             unsupported,
    output logic                             result_wr,
    output logic      [csra_pkg::FLD_W-1:0]  result_addr,
    output logic      [csra_pkg::XLEN-1:0]   result_data,
    output logic                             zero_flag,
    output logic                             carry_flag,
    output logic                             jump_taken,
    output logic      [csra_pkg::FLD_W-1:0]  jump_target
);
    import csra_pkg::*;

    if (DEPTH < 16 || DEPTH > (1 << FLD_W)) begin : g_depth_check
        $error("DEPTH must lie between 16 and 512");
    end
    if (REG_DEPTH != (1 << FLD_W)) begin : g_default_depth_check
        $error("default depth must fill the register address space");
    end

    // Decode assumes the instruction fields tile the word with no gap or overlap
    if (OPC_LSB + OPC_W != XLEN) begin : g_opc_check
        $error("opcode field must end at the top bit");
    end
    if (ZW_BIT + 1 != OPC_LSB || CW_BIT + 1 != ZW_BIT) begin : g_flag_bit_check
        $error("flag write bits must sit below the opcode");
    end
    if (RW_BIT + 1 != CW_BIT || IMM_BIT + 1 != RW_BIT) begin : g_mode_bit_check
        $error("write and immediate bits misplaced");
    end
    if (COND_LSB + COND_W != IMM_BIT) begin : g_cond_check
        $error("condition field must sit below the immediate bit");
    end
    if (DST_LSB + FLD_W != COND_LSB || SRC_LSB + FLD_W != DST_LSB) begin : g_field_check
        $error("register fields must tile the low bits");
    end
    // Shift counts must reach every bit position and no further
    if ((1 << CNT_W) != XLEN) begin : g_count_check
        $error("count width does not match the word width");
    end
    // The four-state sequence is what fixes the execution time
    if (EXEC_CLOCKS != 4) begin : g_clock_check
        $error("sequencer is built for exactly four clocks");
    end

    typedef struct packed {
        csra_state_t                st;
        logic [XLEN-1:0]            instr;
        logic [XLEN-1:0]            dval;
        logic [XLEN-1:0]            sval;
        logic [XLEN-1:0]            rslt;
        logic                       cy;
        logic                       run;
        logic [DEPTH-1:0][XLEN-1:0] regs;
        logic                       z;
        logic                       c;
        logic [XLEN-1:0]            peek;
        logic                       done;
        logic                       exe;
        logic                       unsup;
        logic                       wr;
        logic [FLD_W-1:0]           waddr;
        logic [XLEN-1:0]            wdata;
        logic                       jump;
        logic [FLD_W-1:0]           jtgt;
    } csra_core_t;

    csra_core_t s_q;
    csra_core_t s_d;

    // True when an address falls inside the implemented register file
    function automatic logic in_range(input logic [FLD_W-1:0] addr);
        return int'(addr) < DEPTH;
    endfunction : in_range

    // Out-of-range reads return zero rather than wrapping
    function automatic logic [XLEN-1:0] reg_read(input logic [DEPTH-1:0][XLEN-1:0] regs,
                                                input logic [FLD_W-1:0] addr);
        logic [XLEN-1:0] v;
        v = '0;
        if (in_range(addr)) begin
            v = regs[addr];
        end
        return v;
    endfunction : reg_read

    // A 9-bit literal or field widened with zero upper bits
    function automatic logic [XLEN-1:0] widen_field(input logic [FLD_W-1:0] f);
        return {{(XLEN-FLD_W){1'b0}}, f};
    endfunction : widen_field

    // Opcodes served by the rotate, shift and bit-mirror unit
    function automatic logic is_shift(input logic [OPC_W-1:0] opc);
        logic hit;
        case (opc)
            OPC_BIT_MIRROR,
            OPC_ROTATE_LEFT,
            OPC_ROTATE_RIGHT,
            OPC_ARITH_RIGHT,
            OPC_LOGIC_LEFT,
            OPC_LOGIC_RIGHT: hit = 1'b1;
            default:         hit = 1'b0;
        endcase
        return hit;
    endfunction : is_shift

    // Anything outside this set completes with no write and no flag change
    function automatic logic is_supported(input logic [OPC_W-1:0] opc);
        return is_shift(opc) || (opc == OPC_SUB_UNSIGNED) || (opc == OPC_JUMP);
    endfunction : is_supported

    // Flag pair {C,Z} indexes the condition field; all ones always runs
    function automatic logic cond_met(input logic [COND_W-1:0] cond,
                                      input logic              c,
                                      input logic              z);
        return cond[{c, z}];
    endfunction : cond_met

    csra_op_if shift_bus ();
    csra_op_if sub_bus ();

    csra_shift_unit u_shift (
        .op (shift_bus.unit)
    );

    csra_sub_unit u_sub (
        .op (sub_bus.unit)
    );

    logic [OPC_W-1:0] opc;
    logic [FLD_W-1:0] dst_f;
    logic [FLD_W-1:0] src_f;
    logic [COND_W-1:0] cond_f;
    logic             zw_f;
    logic             cw_f;
    logic             rw_f;
    logic             imm_f;
    logic             use_shift;
    logic             use_sub;

    assign opc    = s_q.instr[OPC_LSB +: OPC_W];
    assign dst_f  = s_q.instr[DST_LSB +: FLD_W];
    assign src_f  = s_q.instr[SRC_LSB +: FLD_W];
    assign cond_f = s_q.instr[COND_LSB +: COND_W];
    assign zw_f      = s_q.instr[ZW_BIT];
    assign cw_f      = s_q.instr[CW_BIT];
    assign rw_f      = s_q.instr[RW_BIT];
    assign imm_f     = s_q.instr[IMM_BIT];
    assign use_shift = is_shift(opc);
    assign use_sub   = (opc == OPC_SUB_UNSIGNED);

    // Both units see the same operands; the sequencer picks one answer
    assign shift_bus.opcode = opc;
    assign shift_bus.dval   = s_q.dval;
    assign shift_bus.sval   = s_q.sval;
    assign sub_bus.opcode   = opc;
    assign sub_bus.dval     = s_q.dval;
    assign sub_bus.sval     = s_q.sval;

    always_comb begin
        s_d       = s_q;
        s_d.done  = 1'b0;
        s_d.wr    = 1'b0;
        s_d.jump  = 1'b0;
        s_d.peek  = reg_read(s_q.regs, peek_addr);
        // Outside loads only land while no instruction is in flight
        if (load_en && s_q.st == CSRA_IDLE && in_range(load_addr)) begin
            s_d.regs[load_addr] = load_data;
        end
        case (s_q.st)
            // Latch the word; operands are read on the next clock
            CSRA_IDLE: begin
                if (instr_valid) begin
                    s_d.instr = instr_word;
                    s_d.st    = CSRA_READ;
                end
            end
            // A load taken together with the instruction is already visible here
            CSRA_READ: begin
                s_d.dval = reg_read(s_q.regs, dst_f);
                if (imm_f) begin
                    s_d.sval = widen_field(src_f);
                end else begin
                    s_d.sval = reg_read(s_q.regs, src_f);
                end
                s_d.run = cond_met(cond_f, s_q.c, s_q.z);
                s_d.st  = CSRA_EXEC;
            end
            // Units are combinational, so their answer is captured here
            CSRA_EXEC: begin
                if (use_shift) begin
                    s_d.rslt = shift_bus.result;
                    s_d.cy   = shift_bus.carry;
                end else if (use_sub) begin
                    s_d.rslt = sub_bus.result;
                    s_d.cy   = sub_bus.carry;
                end else begin
                    s_d.rslt = widen_field(s_q.sval[FLD_W-1:0]);
                    s_d.cy   = s_q.c;
                end
                s_d.st = CSRA_COMMIT;
            end
            // Flags and write-back land together with the done pulse
            CSRA_COMMIT: begin
                s_d.done  = 1'b1;
                s_d.exe   = s_q.run;
                s_d.unsup = !is_supported(opc);
                s_d.st    = CSRA_IDLE;
                if (s_q.run && !s_d.unsup) begin
                    if (zw_f) begin
                        s_d.z = (s_q.rslt == '0);
                    end
                    if (opc == OPC_JUMP) begin
                        // Return form: target is the low 9 bits of the source operand (immediate or register), result never written
                        s_d.jump = 1'b1;
                        s_d.jtgt = s_q.rslt[FLD_W-1:0];
                    end else begin
                        if (cw_f) begin
                            s_d.c = s_q.cy;
                        end
                        if (rw_f) begin
                            s_d.wr    = 1'b1;
                            s_d.waddr = dst_f;
                            s_d.wdata = s_q.rslt;
                            if (in_range(dst_f)) begin
                                s_d.regs[dst_f] = s_q.rslt;
                            end
                        end
                    end
                end
            end
            default: begin
                s_d.st = CSRA_IDLE;
            end
        endcase
    end

    // Register file and flags clear together with the sequencer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q       <= '0;
            s_q.st    <= CSRA_IDLE;
            s_q.regs  <= {DEPTH{REG_RESET}};
            s_q.z     <= FLAG_RESET;
            s_q.c     <= FLAG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Every output is a register copy except ready
    assign instr_ready = (s_q.st == CSRA_IDLE);
    assign peek_data   = s_q.peek;
    assign done        = s_q.done;
    assign executed    = s_q.exe;
    assign unsupported = s_q.unsup;
    assign result_wr   = s_q.wr;
    assign result_addr = s_q.waddr;
    assign result_data = s_q.wdata;
    assign zero_flag   = s_q.z;
    assign carry_flag  = s_q.c;
    assign jump_taken  = s_q.jump;
    assign jump_target = s_q.jtgt;

endmodule : cog_shift_rotate_sub_alu

// ---- sim/csra_monitor.sv ----
// Protocol and flag checker bound to the shift/rotate/subtract slice
`timescale 1ns/100ps
module csra_monitor
    import csra_pkg::*;
#(
    parameter int DEPTH = REG_DEPTH
) (
    input wire logic                ref_clk,
    input wire logic                reset_n,
    input wire logic                instr_valid,
    input wire logic [XLEN-1:0]     instr_word,
    input wire logic                instr_ready,
    input wire logic                done,
    input wire logic                unsupported,
    input wire logic                result_wr,
    input wire logic [XLEN-1:0]     result_data,
    input wire logic                zero_flag,
    input wire logic                carry_flag,
    input wire logic                jump_taken
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_take;
        instr_valid && instr_ready;
    endsequence
    sequence s_busy;
        !instr_ready [*3] ##1 instr_ready;
    endsequence
    sequence s_sub_zw;
        s_take ##0 (instr_word[31:26] == OPC_SUB_UNSIGNED && instr_word[ZW_BIT]
                    && instr_word[RW_BIT] && instr_word[21:18] == 4'hf);
    endsequence

    a_done_after_take: assert property (s_take |-> ##4 done)
        else $error("done not four clocks after take");
    a_ready_while_busy: assert property (s_take |=> s_busy)
        else $error("ready wrong during execution");
    a_done_one_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_write_needs_bit: assert property (s_take ##0 !instr_word[RW_BIT] |-> ##4 !result_wr)
        else $error("result written with write bit clear");
    a_carry_kept: assert property (s_take ##0 !instr_word[CW_BIT] |-> ##4 $stable(carry_flag))
        else $error("carry changed without carry write");
    a_zero_tracks: assert property (s_sub_zw |-> ##4 zero_flag == (result_data == '0))
        else $error("zero flag does not match result");
    a_write_with_done: assert property (result_wr |-> done && !unsupported)
        else $error("write pulse outside a supported completion");
    a_jump_no_write: assert property (jump_taken |-> done && !result_wr)
        else $error("jump wrote a register");
    a_unsup_quiet: assert property (done && unsupported |->
        !result_wr && $stable(zero_flag) && $stable(carry_flag))
        else $error("unsupported opcode changed state");
endmodule : csra_monitor

bind cog_shift_rotate_sub_alu csra_monitor #(.DEPTH(DEPTH)) csra_monitor_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .done(done),
    .unsupported(unsupported), .result_wr(result_wr), .result_data(result_data),
    .zero_flag(zero_flag), .carry_flag(carry_flag), .jump_taken(jump_taken));

// ---- sim/tb_top.sv ----
// Self-checking bench of the shift/rotate/subtract slice
`timescale 1ns/100ps
module tb_top;
    import csra_pkg::*;
    logic        ref_clk, reset_n, instr_valid, load_en, instr_ready, done, executed;
    logic        unsupported, result_wr, zero_flag, carry_flag, jump_taken;
    logic        wr_seen, jt_seen, un_seen;
    logic [31:0] instr_word, load_data, peek_data, result_data, pv;
    logic [8:0]  load_addr, peek_addr, result_addr, jump_target;
    logic [5:0]  ops [6] = '{OPC_BIT_MIRROR, OPC_ROTATE_LEFT, OPC_ROTATE_RIGHT,
                             OPC_ARITH_RIGHT, OPC_LOGIC_LEFT, OPC_LOGIC_RIGHT};
    int          fail_count = 0;
    int          total_checks = 0;

    cog_shift_rotate_sub_alu cog_shift_rotate_sub_alu_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .load_en(load_en),
        .load_addr(load_addr), .load_data(load_data), .peek_addr(peek_addr),
        .peek_data(peek_data), .done(done), .executed(executed),
        .unsupported(unsupported), .result_wr(result_wr), .result_addr(result_addr),
        .result_data(result_data), .zero_flag(zero_flag), .carry_flag(carry_flag),
        .jump_taken(jump_taken), .jump_target(jump_target));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] mk(logic [5:0] opc, logic zw, logic cw, logic rw,
                                       logic im, logic [8:0] d, logic [8:0] s);
        return {opc, zw, cw, rw, im, 4'hf, d, s};
    endfunction : mk

    // Reference result of the six shift-type operations, k indexes ops
    function automatic logic [31:0] xshift(int k, logic [31:0] v, int c);
        logic [31:0] r;
        case (k)
            0: begin
                for (int i = 0; i < 32; i++) r[i] = v[31-i];
                r = r >> c;
            end
            1: r = (v << c) | (v >> (32 - c));
            2: r = (v >> c) | (v << (32 - c));
            3: r = $signed(v) >>> c;
            4: r = v << c;
            default: r = v >> c;
        endcase
        return r;
    endfunction : xshift

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic load(logic [8:0] a, logic [31:0] d);
        @(posedge ref_clk);
        load_en <= 1'b1;
        load_addr <= a;
        load_data <= d;
        @(posedge ref_clk);
        load_en <= 1'b0;
    endtask : load

    task automatic peek(logic [8:0] a);
        @(posedge ref_clk);
        peek_addr <= a;
        @(posedge ref_clk);
        #1 pv = peek_data;
    endtask : peek

    // Issue one instruction and wait for its completion pulse
    task automatic exec(logic [31:0] w);
        int n;
        n = 0;
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (done !== 1'b1 && n < 10);
        wr_seen = result_wr;
        jt_seen = jump_taken;
        un_seen = unsupported;
        chk(n, EXEC_CLOCKS - 1);
    endtask : exec

    task automatic t_shift_ops;
        logic [31:0] r;
        for (int k = 0; k < 6; k++) begin
            load(9'(k + 1), 32'h8765_4320);
            exec(mk(ops[k], 1'b1, 1'b1, 1'b1, 1'b1, 9'(k + 1), 9'(3 + 5 * k)));
            r = xshift(k, 32'h8765_4320, 3 + 5 * k);
            chk(result_data, r);
            chk(carry_flag, (k == 1 || k == 4) ? 1'b1 : 1'b0);
            chk(zero_flag, r == 32'h0);
            peek(9'(k + 1));
            chk(pv, r);
        end
    endtask : t_shift_ops

    task automatic t_reg_count;
        load(9'd40, 32'h0000_0001);
        load(9'd41, 32'hffff_ffe1);
        exec(mk(OPC_LOGIC_RIGHT, 1'b1, 1'b1, 1'b1, 1'b0, 9'd40, 9'd41));
        chk(result_data, 32'h0);
        chk(zero_flag, 1'b1);
        chk(carry_flag, 1'b1);
    endtask : t_reg_count

    task automatic t_sub;
        load(9'd50, 32'h0000_0005);
        exec(mk(OPC_SUB_UNSIGNED, 1'b1, 1'b1, 1'b1, 1'b1, 9'd50, 9'h1ff));
        chk(result_data, 32'hffff_fe06);
        chk(carry_flag, 1'b1);
        chk(zero_flag, 1'b0);
        chk(result_addr, 9'd50);
        chk(executed, 1'b1);
        load(9'd51, 32'hffff_fe06);
        exec(mk(OPC_SUB_UNSIGNED, 1'b1, 1'b1, 1'b1, 1'b0, 9'd50, 9'd51));
        chk(result_data, 32'h0);
        chk(zero_flag, 1'b1);
        chk(carry_flag, 1'b0);
    endtask : t_sub

    task automatic t_nowrite;
        load(9'd60, 32'h8000_0000);
        exec(mk(OPC_LOGIC_LEFT, 1'b1, 1'b1, 1'b0, 1'b1, 9'd60, 9'd1));
        chk(wr_seen, 1'b0);
        chk(carry_flag, 1'b1);
        chk(zero_flag, 1'b1);
        peek(9'd60);
        chk(pv, 32'h8000_0000);
    endtask : t_nowrite

    task automatic t_return;
        exec(mk(OPC_JUMP, 1'b0, 1'b0, 1'b0, 1'b1, 9'd0, 9'h0a5));
        chk(jt_seen, 1'b1);
        chk(wr_seen, 1'b0);
        chk(jump_target, 9'h0a5);
        chk(executed, 1'b1);
        exec(mk(6'h00, 1'b1, 1'b1, 1'b1, 1'b1, 9'd60, 9'd1));
        chk(un_seen, 1'b1);
        chk(wr_seen, 1'b0);
        // Condition field cleared: the shift must not run, write or touch flags
        exec(mk(OPC_LOGIC_LEFT, 1'b1, 1'b1, 1'b1, 1'b1, 9'd1, 9'd1) & 32'hffc3_ffff);
        chk(executed, 1'b0);
        chk(wr_seen, 1'b0);
        chk(zero_flag, 1'b1);
    endtask : t_return

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        reset_n = 1'b0;
        instr_valid = 1'b0;
        instr_word = 32'h0;
        load_en = 1'b0;
        load_addr = 9'h0;
        load_data = 32'h0;
        peek_addr = 9'h0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_shift_ops();
        t_reg_count();
        t_sub();
        t_nowrite();
        t_return();
        report_and_stop();
    end
endmodule : tb_top
